// ### shared/dtc_pkg.sv
package dtc_pkg;
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam logic [2:0] RTT_CODE_OFF = 3'h0;
	localparam int unsigned MR_BIT_ODT_BUF_DIS = 5;
	localparam int unsigned MR_NOM_TERM_LSB = 8;
	localparam int unsigned MR_RTT_WR_LSB = 9;
	localparam int unsigned MR_RTT_PARK_LSB = 6;
	localparam logic [4:0] LAT_PRE1_SUB = 5'h2;
	localparam logic [4:0] LAT_PRE2_SUB = 5'h3;
	localparam logic [4:0] BC4_OFF_ADD = 5'h4;
	localparam logic [4:0] BL8_OFF_ADD = 5'h6;
	localparam logic [4:0] CRC_OFF_ADD = 5'h1;
	localparam logic [4:0] PRE_PD_SUB = 5'h1;
	localparam int unsigned HIST_DEPTH = 32;
	localparam logic [15:0] APB_CTRL_OFS = 16'h0000;
	localparam logic [15:0] APB_MR_OFS = 16'h0004;
	localparam logic [15:0] APB_STAT_OFS = 16'h0008;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] MR_RESET = 32'h0000_0000;
	localparam int unsigned CTRL_WL_LSB = 0;
	localparam int unsigned CTRL_AL_LSB = 8;
	localparam int unsigned CTRL_PL_LSB = 16;
	localparam int unsigned CTRL_PRE2 = 24;
	localparam int unsigned CTRL_CRC = 25;
	localparam int unsigned CTRL_DLL_OFF = 26;

	typedef enum logic [1:0] {
		DTC_TERM_PARK = 2'h0,
		DTC_TERM_NOM = 2'h1,
		DTC_TERM_WR = 2'h2
	} dtc_term_t;

	typedef struct packed {
		logic       psel;
		logic       penable;
		logic       pwrite;
		logic [15:0] paddr;
		logic [31:0] pwdata;
	} dtc_apb_req_t;

	typedef struct packed {
		dtc_term_t  sel;
		logic [2:0] code;
	} dtc_rtt_t;
endpackage

// ### src/dtc_delay_line.sv
`timescale 1ns/100ps
// Delay line of pin and write events; tap chosen per latency at run time.
module dtc_delay_line (
	input  wire logic        clk_sys_in,
	input  wire logic        reset_in,
	input  wire logic [1:0]  event_in,
	output logic [31:0]      odt_hist_out,
	output logic [31:0]      wr_hist_out
);
	import dtc_pkg::*;
	logic [31:0] odt_q, odt_d, wr_q, wr_d;
	always_comb begin
		odt_d = {odt_q[30:0], event_in[0]};
		wr_d  = {wr_q[30:0], event_in[1]};
	end
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			odt_q <= 32'h0000_0000;
			wr_q  <= 32'h0000_0000;
		end else begin
			odt_q <= odt_d;
			wr_q  <= wr_d;
		end
	end
	assign odt_hist_out = odt_q;
	assign wr_hist_out  = wr_q;
endmodule

// ### src/dtc_term_ctrl.sv
`timescale 1ns/100ps
// Behaviour
// - Write termination starts write_latency minus 2 or 3 clocks after write.
// - Burst-chop-4 write ends write termination at write_latency plus 4, or 5 with CRC.
// - Burst-8 write ends write termination at write_latency plus 6, or 7 with CRC.
// - Delay-locked loop off selects asynchronous timing, otherwise synchronous.
// - Asynchronous mode ignores additive and parity latency on the pin.
// - Asynchronous pin high reaches nominal within the turn-on window.
// - Asynchronous pin low reaches park within the turn-off window.
// - Buffer-disable option blocks nominal termination during power down.
// - Pin samples after clock-enable low or write_latency minus 1 before entry dropped.
// - Write termination enabled only when its code is nonzero.
// - Nominal, write and park codes come from their mode register fields.
// - Outside writes nominal follows pin with direct latencies; park when low.
// - Write termination never operates with the delay-locked loop off.
module dtc_term_ctrl (
	input  wire logic             clk_sys_in,
	input  wire logic             reset_in,
	input  wire logic             odt_pin_in,
	input  wire logic             cke_pin_in,
	input  wire logic             write_cmd_in,
	input  wire logic             write_bc4_in,
	input  wire dtc_pkg::dtc_apb_req_t apb_req_in,
	output logic [31:0]           prdata_out,
	output logic                  pready_out,
	output logic                  pslverr_out,
	output dtc_pkg::dtc_rtt_t     rtt_out
);
	import dtc_pkg::*;

	function automatic logic [4:0] tap_sat(input logic [5:0] v);
		tap_sat = (v > 6'd31) ? 5'h1F : v[4:0];
	endfunction

	// Two-stage synchronisers for pins from the controller.
	logic odt_s1_q, odt_s2_q, cke_s1_q, cke_s2_q;
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			odt_s1_q <= 1'b0;
			odt_s2_q <= 1'b0;
			cke_s1_q <= 1'b1;
			cke_s2_q <= 1'b1;
		end else begin
			odt_s1_q <= odt_pin_in;
			odt_s2_q <= odt_s1_q;
			cke_s1_q <= cke_pin_in;
			cke_s2_q <= cke_s1_q;
		end
	end

	// APB registers.
	logic [31:0] ctrl_q, ctrl_d, mr_q, mr_d, prdata_q, prdata_d;
	logic        pready_q, pready_d, pslverr_q, pslverr_d;
	logic        access;
	logic [31:0] stat;
	always_comb begin
		ctrl_d    = ctrl_q;
		mr_d      = mr_q;
		prdata_d  = prdata_q;
		pslverr_d = 1'b0;
		access    = apb_req_in.psel && apb_req_in.penable && !pready_q;
		pready_d  = access;
		if (access) begin
			unique case (apb_req_in.paddr)
				APB_CTRL_OFS: begin
					if (apb_req_in.pwrite) ctrl_d = apb_req_in.pwdata;
					prdata_d = ctrl_q;
				end
				APB_MR_OFS: begin
					if (apb_req_in.pwrite) mr_d = apb_req_in.pwdata;
					prdata_d = mr_q;
				end
				APB_STAT_OFS: begin
					prdata_d  = stat;
					pslverr_d = apb_req_in.pwrite;
				end
				default: begin
					prdata_d  = 32'h0000_0000;
					pslverr_d = 1'b1;
				end
			endcase
		end
	end
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			ctrl_q    <= CTRL_RESET;
			mr_q      <= MR_RESET;
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			ctrl_q    <= ctrl_d;
			mr_q      <= mr_d;
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// Mode fields. The MR register packs MR1 nominal, MR2 write, MR5 park and buffer-disable.
	logic [4:0] wl, al, pl;
	logic       pre2, crc, dll_off, buf_dis;
	logic [2:0] nom_code, wr_code, park_code;
	always_comb begin
		wl        = ctrl_q[CTRL_WL_LSB +: 5];
		al        = ctrl_q[CTRL_AL_LSB +: 5];
		pl        = ctrl_q[CTRL_PL_LSB +: 5];
		pre2      = ctrl_q[CTRL_PRE2];
		crc       = ctrl_q[CTRL_CRC];
		dll_off   = ctrl_q[CTRL_DLL_OFF];
		nom_code  = mr_q[MR_NOM_TERM_LSB +: 3];
		wr_code   = mr_q[16 + MR_RTT_WR_LSB +: 3];
		park_code = mr_q[24 + MR_RTT_PARK_LSB - 6 +: 3];
		buf_dis   = mr_q[28 + MR_BIT_ODT_BUF_DIS - 5];
	end

	// Event history: odt sample and write command per clock.
	logic [31:0] odt_hist, wr_hist;
	logic        wr_ev;
	logic        write_bc4_q;
	logic        pd_block_q, pd_block_d, nom_req;
	assign wr_ev = write_cmd_in && !dll_off && (wr_code != RTT_CODE_OFF);
	dtc_delay_line u_hist (
		.clk_sys_in   (clk_sys_in),
		.reset_in     (reset_in),
		.event_in     ({wr_ev, odt_s2_q && !pd_block_q}),
		.odt_hist_out (odt_hist),
		.wr_hist_out  (wr_hist)
	);

	// Write window: counter loaded at write, on/off points from latencies.
	logic [5:0] wcnt_q, wcnt_d;
	logic [4:0] on_lat, off_lat, odt_lat;
	logic       in_wr;
	always_comb begin
		on_lat  = tap_sat({1'b0, wl} - {1'b0, (pre2 ? LAT_PRE2_SUB : LAT_PRE1_SUB)});
		off_lat = tap_sat({1'b0, wl} + {1'b0, (write_bc4_q ? BC4_OFF_ADD : BL8_OFF_ADD)}
			+ {1'b0, (crc ? CRC_OFF_ADD : 5'h0)});
		odt_lat = tap_sat({1'b0, wl} + {1'b0, al} + {1'b0, pl}
			- {1'b0, (pre2 ? LAT_PRE2_SUB : LAT_PRE1_SUB)});
		wcnt_d  = wr_ev ? 6'h01 : ((wcnt_q != 6'h00 && wcnt_q < 6'h3F) ? wcnt_q + 6'h01 : 6'h00);
		if (wcnt_q > {1'b0, off_lat}) wcnt_d = 6'h00;
		in_wr   = (wcnt_q > {1'b0, on_lat}) && (wcnt_q <= {1'b0, off_lat});
	end
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			wcnt_q      <= 6'h00;
			write_bc4_q <= 1'b0;
		end else begin
			wcnt_q      <= wcnt_d;
			if (wr_ev) write_bc4_q <= write_bc4_in;
		end
	end

	// Power down tracking: clock enable low blocks pin samples when option set.
	always_comb begin
		pd_block_d = buf_dis && !cke_s2_q;
		// Asynchronous mode takes the pin straight, no added latencies.
		nom_req = dll_off ? (odt_s2_q && !pd_block_q) : odt_hist[odt_lat];
		if (pd_block_q) nom_req = 1'b0;
		if (buf_dis && odt_lat > PRE_PD_SUB && !cke_s2_q && !dll_off)
			nom_req = 1'b0;
	end

	dtc_rtt_t rtt_q, rtt_d;
	always_comb begin
		if (in_wr) begin
			rtt_d.sel  = DTC_TERM_WR;
			rtt_d.code = wr_code;
		end else if (nom_req && nom_code != RTT_CODE_OFF) begin
			rtt_d.sel  = DTC_TERM_NOM;
			rtt_d.code = nom_code;
		end else begin
			rtt_d.sel  = DTC_TERM_PARK;
			rtt_d.code = park_code;
		end
	end
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			rtt_q      <= '{sel: DTC_TERM_PARK, code: 3'h0};
			pd_block_q <= 1'b0;
		end else begin
			rtt_q      <= rtt_d;
			pd_block_q <= pd_block_d;
		end
	end

	assign stat        = {24'h0, pd_block_q, in_wr, dll_off, rtt_q.code, rtt_q.sel};
	assign prdata_out  = prdata_q;
	assign pready_out  = pready_q;
	assign pslverr_out = pslverr_q;
	assign rtt_out     = rtt_q;

	property p_async_on;
		@(posedge clk_sys_in) disable iff (reset_in)
		(dll_off && odt_s2_q && !pd_block_q && !in_wr && nom_code != 3'h0) |=> rtt_q.sel == DTC_TERM_NOM;
	endproperty
	a_async_on: assert property (p_async_on) else $error("async turn-on late");
	property p_async_off;
		@(posedge clk_sys_in) disable iff (reset_in)
		(dll_off && !odt_s2_q && !in_wr) |=> rtt_q.sel == DTC_TERM_PARK;
	endproperty
	a_async_off: assert property (p_async_off) else $error("async turn-off late");
	property p_no_wr_dll_off;
		@(posedge clk_sys_in) disable iff (reset_in) dll_off |-> !wr_ev;
	endproperty
	a_no_wr_dll_off: assert property (p_no_wr_dll_off) else $error("write termination in dll off");
	property p_pd_nom;
		@(posedge clk_sys_in) disable iff (reset_in) pd_block_q |=> rtt_q.sel != DTC_TERM_NOM;
	endproperty
	a_pd_nom: assert property (p_pd_nom) else $error("nominal in power down");
	property p_wr_code;
		@(posedge clk_sys_in) disable iff (reset_in) wr_ev |-> wr_code != 3'h0;
	endproperty
	a_wr_code: assert property (p_wr_code) else $error("write termination with zero code");
	property p_wr_sel;
		@(posedge clk_sys_in) disable iff (reset_in) in_wr |=> rtt_q.sel == DTC_TERM_WR;
	endproperty
	a_wr_sel: assert property (p_wr_sel) else $error("write window not applied");
	property p_wr_on;
		@(posedge clk_sys_in) disable iff (reset_in)
		(wr_ev && wl == 5'h9 && !pre2 && !$past(wr_ev)) |-> ##8 in_wr;
	endproperty
	a_wr_on: assert property (p_wr_on) else $error("write turn-on latency");
	property p_wr_off;
		@(posedge clk_sys_in) disable iff (reset_in)
		(wr_ev && wl == 5'h9 && !crc && !write_bc4_in) ##1 (!wr_ev) [*8] |-> ##8 !in_wr;
	endproperty
	a_wr_off: assert property (p_wr_off) else $error("write turn-off latency");
	c_wr: cover property (@(posedge clk_sys_in) in_wr);
	c_nom: cover property (@(posedge clk_sys_in) rtt_q.sel == DTC_TERM_NOM);
	c_pd: cover property (@(posedge clk_sys_in) pd_block_q);
endmodule

// ### test/dtc_ctl_model.sv
`timescale 1ns/100ps
// Controller side: drives the termination pin, clock enable and write commands.
module dtc_ctl_model #(
	parameter int CPD_DELAY = 4,
	parameter int XP_DELAY  = 5
) (
	input  wire logic clk_sys_in,
	output logic      odt_pin_out,
	output logic      cke_pin_out,
	output logic      write_cmd_out,
	output logic      write_bc4_out
);
	logic float_q = 1'h0;
	initial begin
		odt_pin_out = 1'h0;
		cke_pin_out = 1'h1;
		write_cmd_out = 1'h0;
		write_bc4_out = 1'h0;
	end
	// A released pin toggles so that no stale level can pass for a driven one.
	always @(posedge clk_sys_in) begin
		if (float_q)
			odt_pin_out <= ~odt_pin_out;
	end
	task automatic set_odt(input logic v);
		@(posedge clk_sys_in);
		odt_pin_out <= v;
	endtask
	task automatic do_write(input logic bc4);
		@(posedge clk_sys_in);
		write_cmd_out <= 1'h1;
		write_bc4_out <= bc4;
		@(posedge clk_sys_in);
		write_cmd_out <= 1'h0;
	endtask
	task automatic pd_enter;
		@(posedge clk_sys_in);
		cke_pin_out <= 1'h0;
		repeat (CPD_DELAY) @(posedge clk_sys_in);
		float_q <= 1'h1;
	endtask
	task automatic pd_exit;
		@(posedge clk_sys_in);
		float_q <= 1'h0;
		@(posedge clk_sys_in);
		cke_pin_out <= 1'h1;
		odt_pin_out <= 1'h0;
		repeat (XP_DELAY) @(posedge clk_sys_in);
	endtask
endmodule

// ### test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	import dtc_pkg::*;
	localparam int ASYNC_MAX = 5;
	logic         clk_sys_in;
	logic         reset_in;
	dtc_apb_req_t req;
	logic [31:0]  prdata;
	logic         pready;
	logic         pslverr;
	dtc_rtt_t     rtt;
	logic         odt;
	logic         cke;
	logic         wcmd;
	logic         bc4;
	logic [31:0]  rd;
	logic [31:0]  mr;
	logic         e;
	int           err_total;
	int           cmp_count;
	int           n;
	int           m;
	int           base;
	int           on[4];
	int           off[4];
	int           cfg[7][4] = '{'{9,0,0,0}, '{9,0,0,1}, '{9,0,1,0}, '{9,0,1,1}, '{12,0,0,0}, '{12,1,0,0}, '{12,1,0,1}};

	dtc_ctl_model ctl (.clk_sys_in(clk_sys_in), .odt_pin_out(odt), .cke_pin_out(cke), .write_cmd_out(wcmd),
		.write_bc4_out(bc4));
	dtc_term_ctrl dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .odt_pin_in(odt), .cke_pin_in(cke),
		.write_cmd_in(wcmd), .write_bc4_in(bc4), .apb_req_in(req), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .rtt_out(rtt));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		req <= '{1'h1, 1'h0, w, a, d};
		@(posedge clk_sys_in);
		req.penable <= 1'h1;
		do
			@(posedge clk_sys_in);
		while (pready !== 1'h1);
		rd = prdata;
		e = pslverr;
		req <= '0;
	endtask
	function automatic logic [31:0] cw(input int wl, al, pre2, crc, dll);
		return 32'(wl) | 32'(al) << CTRL_AL_LSB | 32'(pre2) << CTRL_PRE2 | 32'(crc) << CTRL_CRC | 32'(dll) << CTRL_DLL_OFF;
	endfunction
	// Gives up after 60 cycles, which is longer than any latency used here.
	task automatic ws(input dtc_term_t s, input logic eq, output int k);
		k = 0;
		do begin
			@(posedge clk_sys_in);
			#1;
			k++;
		end while ((rtt.sel === s) !== eq && k < 60);
	endtask

	initial begin
		clk_sys_in = 1'h0;
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end
	initial begin
		#500000;
		err_total++;
		wrap_up();
	end
	initial begin
		reset_in = 1'h1;
		req = '0;
		repeat (3) @(posedge clk_sys_in);
		reset_in <= 1'h0;
		apb(1'h0, APB_CTRL_OFS, '0);
		chk(rd, CTRL_RESET);
		apb(1'h0, APB_MR_OFS, '0);
		chk(rd, MR_RESET);
		apb(1'h1, APB_STAT_OFS, 32'h1);
		chk(32'(e), 32'h1);
		apb(1'h0, 16'h000C, '0);
		chk(32'(e), 32'h1);
		mr = 32'h0000_0500 | 32'h3 << 25;
		apb(1'h1, APB_MR_OFS, mr);
		apb(1'h0, APB_MR_OFS, '0);
		chk(rd, mr);
		$display("test registers done");
		for (int i = 0; i < 7; i++) begin
			apb(1'h1, APB_CTRL_OFS, cw(cfg[i][0], 0, cfg[i][1], cfg[i][2], 0));
			ctl.do_write(cfg[i][3][0]);
			ws(DTC_TERM_WR, 1'h1, n);
			chk(32'(rtt.code), 32'(mr[27:25]));
			ws(DTC_TERM_WR, 1'h0, m);
			chk(32'(m), 32'((cfg[i][3] ? 4 : 6) + cfg[i][2] + 2 + cfg[i][1]));
			chk(32'(rtt), 32'({DTC_TERM_PARK, mr[26:24]}));
			if (i == 0)
				base = n;
			chk(32'(n), 32'(base + cfg[i][0] - 9 - cfg[i][1]));
		end
		$display("test write windows done");
		apb(1'h1, APB_CTRL_OFS, cw(9, 0, 0, 0, 0));
		ctl.set_odt(1'h1);
		ws(DTC_TERM_NOM, 1'h1, n);
		chk(32'(rtt.code), 32'h5);
		ctl.do_write(1'h0);
		ws(DTC_TERM_WR, 1'h1, n);
		ws(DTC_TERM_WR, 1'h0, n);
		chk(32'(rtt.sel), 32'(DTC_TERM_NOM));
		ctl.set_odt(1'h0);
		ws(DTC_TERM_PARK, 1'h1, n);
		$display("test overlap done");
		for (int i = 0; i < 4; i++) begin
			apb(1'h1, APB_CTRL_OFS, cw(9, i[0] ? 4 : 0, 0, 0, i[1]));
			ctl.set_odt(1'h1);
			ws(DTC_TERM_NOM, 1'h1, on[i]);
			ctl.set_odt(1'h0);
			ws(DTC_TERM_PARK, 1'h1, off[i]);
		end
		chk(32'(on[1] - on[0]), 32'h4);
		chk(32'(off[1] - off[0]), 32'h4);
		chk(32'(on[3] - on[2]), 32'h0);
		chk(32'(on[2] <= ASYNC_MAX && on[0] > on[2]), 32'h1);
		chk(32'(off[3] <= ASYNC_MAX), 32'h1);
		apb(1'h0, APB_STAT_OFS, '0);
		chk(32'(rd[5]), 32'h1);
		ctl.do_write(1'h0);
		ws(DTC_TERM_WR, 1'h1, n);
		chk(32'(n), 32'h3C);
		apb(1'h1, APB_CTRL_OFS, cw(9, 0, 0, 0, 0));
		apb(1'h1, APB_MR_OFS, 32'h0000_0500);
		ctl.do_write(1'h0);
		ws(DTC_TERM_WR, 1'h1, n);
		chk(32'(n), 32'h3C);
		$display("test pin timing done");
		apb(1'h1, APB_MR_OFS, mr | 32'h1 << 28);
		ctl.set_odt(1'h1);
		ctl.pd_enter();
		m = 0;
		repeat (30) begin
			@(posedge clk_sys_in);
			#1;
			m += (rtt.sel === DTC_TERM_NOM);
		end
		chk(32'(m), 32'h0);
		apb(1'h0, APB_STAT_OFS, '0);
		chk(32'(rd[7]), 32'h1);
		ctl.pd_exit();
		ctl.set_odt(1'h1);
		ws(DTC_TERM_NOM, 1'h1, n);
		chk(32'(rtt.sel), 32'(DTC_TERM_NOM));
		$display("test power down done");
		wrap_up();
	end
endmodule
